// ### plmc_hash.sv
`timescale 1ns/10ps
module plmc_hash (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        dataValid,
  input  wire logic [31:0] data,
  output logic      [55:0] crc
);

  logic [31:0] crc32;
  logic [15:0] crc16;
  logic [7:0]  crc8;

  function automatic logic [31:0] step32(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ plmc_pkg::CRC32_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] step16(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ plmc_pkg::CRC16_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] c, input logic [31:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = (r[7] ^ d[i]) ? ((r << 1) ^ plmc_pkg::CRC8_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
    begin
      crc32 <= plmc_pkg::CRC32_INIT;
      crc16 <= plmc_pkg::CRC16_INIT;
      crc8  <= plmc_pkg::CRC8_INIT;
    end
    else if (dataValid)
    begin
      crc32 <= step32(crc32, data);
      crc16 <= step16(crc16, data);
      crc8  <= step8(crc8, data);
    end
  end

  assign crc = {crc8, crc16, crc32};

endmodule

// ### plmc_lookup.sv
`timescale 1ns/10ps
module plmc_lookup (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [8:0]   regAddr,
  input  wire logic [31:0]  regWrData,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic      [31:0]  regRdData,
  input  wire logic         pktStart,
  input  wire logic [3:0]   pktProfile,
  input  wire logic         pktLongKey,
  input  wire logic [23:0]  pktFlowTablePtr,
  input  wire logic [319:0] pktKey,
  output logic              pktBusy,
  input  wire logic         optValid,
  input  wire logic [1:0]   optKind,
  input  wire logic [7:0]   optValue,
  output logic      [1:0]   optCode,
  output logic              optSkip,
  output logic              optCpu,
  output logic              optDelete,
  input  wire logic         tosValid,
  input  wire logic         tosIsV6,
  input  wire logic [7:0]   tosValue,
  output logic      [1:0]   tosCode,
  output logic              prioLow,
  output logic              prioHigh,
  output logic              memReq,
  output logic      [23:0]  memAddr,
  input  wire logic         memAck,
  input  wire logic [31:0]  memData,
  output logic              resValid,
  output logic      [1:0]   resKind,
  output logic      [3:0]   resDest,
  output logic      [3:0]   resProfile
);

  logic [31:0]            profMem [0:255];
  logic [23:0]            treeRoot;
  plmc_pkg::plmc_state_e  state;
  logic [3:0]             profile;
  logic                   longKey;
  logic [23:0]            ftPtr;
  logic [319:0]           keyReg;
  logic [31:0]            keyDw [0:plmc_pkg::KEY_DWORDS-1];
  logic [3:0]             wordIdx;
  logic [23:0]            curBase;
  logic [59:0]            searchKey;
  logic [31:0]            nodeKeyLo;
  logic [27:0]            nodeKeyHi;
  logic [23:0]            nodeLeft;
  logic [23:0]            nodeRight;
  logic                   confMiss;
  logic [23:0]            confNext;
  logic [7:0]             ipIdx;
  logic [3:0]             confDest;
  logic [3:0]             keyLen;
  logic [31:0]            curMasked;
  logic                   hashClear;
  logic                   hashValid;
  logic [55:0]            crc;
  logic [59:0]            nodeKey;
  logic                   nextWordLast;

  function automatic logic [31:0] applyMask(input logic [31:0] d, input logic [31:0] m);
    return d & m;
  endfunction

  function automatic logic [1:0] pickCode(input logic [31:0] w, input logic [3:0] sel);
    return w[{sel, 1'b0} +: 2];
  endfunction

  genvar g;
  generate
    for (g = 0; g < plmc_pkg::KEY_DWORDS; g++)
    begin : gUnpack
      assign keyDw[g] = keyReg[32*g +: 32];
    end
  endgenerate

  assign keyLen    = longKey ? plmc_pkg::LONG_KEY_LEN : plmc_pkg::SHORT_KEY_LEN;
  assign curMasked = applyMask(keyDw[wordIdx], profMem[{profile, wordIdx}]);
  assign hashValid = (state == plmc_pkg::ST_HASH) && (wordIdx < keyLen);
  assign nodeKey   = {nodeKeyHi, nodeKeyLo};
  assign pktBusy   = (state != plmc_pkg::ST_IDLE);
  assign memReq    = (state == plmc_pkg::ST_NODE) || (state == plmc_pkg::ST_CONF) ||
                     (state == plmc_pkg::ST_FLOW) || (state == plmc_pkg::ST_DFLT);
  assign memAddr   = curBase + (24'(wordIdx) * plmc_pkg::WORD_BYTES);
  assign nextWordLast = (wordIdx == keyLen - 4'h1);

  plmc_hash uHash (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (hashClear),
    .dataValid (hashValid),
    .data      (curMasked),
    .crc       (crc)
  );

  // Profile memory and registers
  always_ff @(posedge sys_clk)
  begin
    if (regWr && !regAddr[plmc_pkg::REG_SEL_BIT])
    begin
      profMem[regAddr[7:0]] <= regWrData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      treeRoot <= plmc_pkg::NULL_PTR;
    end
    else if (regWr && regAddr == plmc_pkg::REG_TREE_ROOT)
    begin
      treeRoot <= regWrData[23:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      regRdData <= 32'h0000_0000;
    end
    else if (regRd)
    begin
      if (!regAddr[plmc_pkg::REG_SEL_BIT])
      begin
        regRdData <= profMem[regAddr[7:0]];
      end
      else if (regAddr == plmc_pkg::REG_TREE_ROOT)
      begin
        regRdData <= {8'h00, treeRoot};
      end
      else if (regAddr == plmc_pkg::REG_STATUS)
      begin
        regRdData <= {24'h00_0000, profile, state, pktBusy};
      end
      else
      begin
        regRdData <= 32'h0000_0000;
      end
    end
    else
    begin
      regRdData <= 32'h0000_0000;
    end
  end

  // Option treatment lookup
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      optCode   <= plmc_pkg::OPT_NONE;
      optSkip   <= 1'b0;
      optCpu    <= 1'b0;
      optDelete <= 1'b0;
    end
    else
    begin
      optSkip   <= 1'b0;
      optCpu    <= 1'b0;
      optDelete <= 1'b0;
      if (optValid)
      begin
        case (optKind)
          plmc_pkg::KIND_V4:
            optCode <= pickCode(profMem[{optValue[7:4], plmc_pkg::W_OPT_V4}], optValue[3:0]);
          plmc_pkg::KIND_HOP:
            optCode <= pickCode(profMem[{optValue[7:4], plmc_pkg::W_OPT_HOP}], optValue[3:0]);
          plmc_pkg::KIND_DEST:
            optCode <= pickCode(profMem[{optValue[7:4], plmc_pkg::W_OPT_DEST}], optValue[3:0]);
          default:
            optCode <= plmc_pkg::OPT_NONE;
        endcase
        optSkip   <= (optKind != 2'h3) && (pickCode(profMem[{optValue[7:4],
                     plmc_pkg::W_OPT_V4 + {2'h0, optKind}}], optValue[3:0]) == plmc_pkg::OPT_SKIP);
        optCpu    <= (optKind != 2'h3) && (pickCode(profMem[{optValue[7:4],
                     plmc_pkg::W_OPT_V4 + {2'h0, optKind}}], optValue[3:0]) == plmc_pkg::OPT_CPU);
        optDelete <= (optKind != 2'h3) && (pickCode(profMem[{optValue[7:4],
                     plmc_pkg::W_OPT_V4 + {2'h0, optKind}}], optValue[3:0]) == plmc_pkg::OPT_DELETE);
      end
    end
  end

  // Service treatment lookup
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tosCode  <= plmc_pkg::TOS_KEEP;
      prioLow  <= 1'b0;
      prioHigh <= 1'b0;
    end
    else
    begin
      prioLow  <= 1'b0;
      prioHigh <= 1'b0;
      if (tosValid)
      begin
        tosCode  <= pickCode(profMem[{tosValue[7:4], tosIsV6 ? plmc_pkg::W_TOS_V6 :
                    plmc_pkg::W_TOS_V4}], tosValue[3:0]);
        prioLow  <= pickCode(profMem[{tosValue[7:4], tosIsV6 ? plmc_pkg::W_TOS_V6 :
                    plmc_pkg::W_TOS_V4}], tosValue[3:0]) == plmc_pkg::TOS_LOW;
        prioHigh <= pickCode(profMem[{tosValue[7:4], tosIsV6 ? plmc_pkg::W_TOS_V6 :
                    plmc_pkg::W_TOS_V4}], tosValue[3:0]) == plmc_pkg::TOS_HIGH;
      end
    end
  end

  // Search sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state      <= plmc_pkg::ST_IDLE;
      profile    <= 4'h0;
      longKey    <= 1'b0;
      ftPtr      <= plmc_pkg::NULL_PTR;
      keyReg     <= '0;
      wordIdx    <= 4'h0;
      curBase    <= plmc_pkg::NULL_PTR;
      searchKey  <= '0;
      nodeKeyLo  <= 32'h0000_0000;
      nodeKeyHi  <= 28'h000_0000;
      nodeLeft   <= plmc_pkg::NULL_PTR;
      nodeRight  <= plmc_pkg::NULL_PTR;
      confMiss   <= 1'b0;
      confNext   <= plmc_pkg::NULL_PTR;
      ipIdx      <= 8'h00;
      confDest   <= 4'h0;
      hashClear  <= 1'b1;
      resValid   <= 1'b0;
      resKind    <= plmc_pkg::RES_ROUTE;
      resDest    <= 4'h0;
      resProfile <= 4'h0;
    end
    else
    begin
      hashClear <= 1'b0;
      resValid  <= 1'b0;
      case (state)
        plmc_pkg::ST_IDLE:
        begin
          if (pktStart)
          begin
            profile   <= pktProfile;
            longKey   <= pktLongKey;
            ftPtr     <= pktFlowTablePtr;
            keyReg    <= pktKey;
            wordIdx   <= 4'h0;
            hashClear <= 1'b1;
            state     <= plmc_pkg::ST_HASH;
          end
        end
        plmc_pkg::ST_HASH:
        begin
          if (hashClear)
          begin
            wordIdx <= 4'h0;
          end
          else if (wordIdx < keyLen)
          begin
            wordIdx <= wordIdx + 4'h1;
          end
          else
          begin
            searchKey <= {profile, crc};
            wordIdx   <= 4'h0;
            curBase   <= (treeRoot == plmc_pkg::NULL_PTR) ?
                         plmc_pkg::DFLT_BASE + 24'(profile) * plmc_pkg::DFLT_STRIDE : treeRoot;
            state     <= (treeRoot == plmc_pkg::NULL_PTR) ? plmc_pkg::ST_DFLT :
                         plmc_pkg::ST_NODE;
          end
        end
        plmc_pkg::ST_NODE:
        begin
          if (memAck)
          begin
            wordIdx <= wordIdx + 4'h1;
            case (wordIdx)
              plmc_pkg::NODE_KEY_LO: nodeKeyLo <= memData;
              plmc_pkg::NODE_KEY_HI: nodeKeyHi <= memData[27:0];
              plmc_pkg::NODE_LEFT:   nodeLeft  <= memData[23:0];
              plmc_pkg::NODE_RIGHT:  nodeRight <= memData[23:0];
              default:
              begin
                wordIdx  <= 4'h0;
                confMiss <= 1'b0;
                if (nodeKey == searchKey && memData[23:0] != plmc_pkg::NULL_PTR)
                begin
                  curBase <= memData[23:0];
                  state   <= plmc_pkg::ST_CONF;
                end
                else if (nodeKey != searchKey && searchKey < nodeKey &&
                         nodeLeft != plmc_pkg::NULL_PTR)
                begin
                  curBase <= nodeLeft;
                end
                else if (nodeKey != searchKey && searchKey > nodeKey &&
                         nodeRight != plmc_pkg::NULL_PTR)
                begin
                  curBase <= nodeRight;
                end
                else
                begin
                  curBase <= plmc_pkg::DFLT_BASE + 24'(profile) * plmc_pkg::DFLT_STRIDE;
                  state   <= plmc_pkg::ST_DFLT;
                end
              end
            endcase
          end
        end
        plmc_pkg::ST_CONF:
        begin
          if (memAck)
          begin
            if (wordIdx < keyLen)
            begin
              confMiss <= confMiss | (memData != curMasked);
              wordIdx  <= nextWordLast ? plmc_pkg::CONF_NEXT_WORD : wordIdx + 4'h1;
            end
            else if (wordIdx == plmc_pkg::CONF_NEXT_WORD)
            begin
              confNext <= memData[23:0];
              wordIdx  <= plmc_pkg::CONF_CTRL_WORD;
            end
            else
            begin
              ipIdx    <= memData[plmc_pkg::CONF_IDX_LSB +: 8];
              confDest <= memData[plmc_pkg::CONF_DEST_LSB +: 4];
              wordIdx  <= 4'h0;
              if (!confMiss && memData[plmc_pkg::CONF_FT_EN_BIT])
              begin
                curBase <= ftPtr + 24'(memData[plmc_pkg::CONF_IDX_LSB +
                           plmc_pkg::FT_WORD_LSB +: 3]) * plmc_pkg::WORD_BYTES;
                state   <= plmc_pkg::ST_FLOW;
              end
              else if (!confMiss)
              begin
                resValid   <= 1'b1;
                resKind    <= plmc_pkg::RES_ROUTE;
                resDest    <= memData[plmc_pkg::CONF_DEST_LSB +: 4];
                resProfile <= profile;
                state      <= plmc_pkg::ST_DONE;
              end
              else if (confNext != plmc_pkg::NULL_PTR)
              begin
                confMiss <= 1'b0;
                curBase  <= confNext;
              end
              else
              begin
                curBase <= plmc_pkg::DFLT_BASE + 24'(profile) * plmc_pkg::DFLT_STRIDE;
                state   <= plmc_pkg::ST_DFLT;
              end
            end
          end
        end
        plmc_pkg::ST_FLOW:
        begin
          if (memAck)
          begin
            if (memData[ipIdx[plmc_pkg::FT_WORD_LSB-1:0]])
            begin
              resValid   <= 1'b1;
              resKind    <= plmc_pkg::RES_ROUTE;
              resDest    <= confDest;
              resProfile <= profile;
              state      <= plmc_pkg::ST_DONE;
            end
            else if (confNext != plmc_pkg::NULL_PTR)
            begin
              confMiss <= 1'b0;
              curBase  <= confNext;
              state    <= plmc_pkg::ST_CONF;
            end
            else
            begin
              curBase <= plmc_pkg::DFLT_BASE + 24'(profile) * plmc_pkg::DFLT_STRIDE;
              state   <= plmc_pkg::ST_DFLT;
            end
          end
        end
        plmc_pkg::ST_DFLT:
        begin
          if (memAck)
          begin
            case (memData[plmc_pkg::DFLT_ACT_LSB +: 2])
              plmc_pkg::DFLT_RESEARCH:
              begin
                profile   <= memData[plmc_pkg::DFLT_PROF_LSB +: 4];
                wordIdx   <= 4'h0;
                hashClear <= 1'b1;
                state     <= plmc_pkg::ST_HASH;
              end
              plmc_pkg::DFLT_CPU:
              begin
                resValid   <= 1'b1;
                resKind    <= plmc_pkg::RES_CPU;
                resDest    <= 4'h0;
                resProfile <= profile;
                state      <= plmc_pkg::ST_DONE;
              end
              default:
              begin
                resValid   <= 1'b1;
                resKind    <= plmc_pkg::RES_DELETE;
                resDest    <= 4'h0;
                resProfile <= profile;
                state      <= plmc_pkg::ST_DONE;
              end
            endcase
          end
        end
        plmc_pkg::ST_DONE:
        begin
          state <= plmc_pkg::ST_IDLE;
        end
        default:
        begin
          state <= plmc_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### plmc_lookup_chk.sv
`timescale 1ns/10ps
module plmc_lookup_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       pktStart,
  input wire logic       pktBusy,
  input wire logic       optValid,
  input wire logic [1:0] optKind,
  input wire logic [1:0] optCode,
  input wire logic       optSkip,
  input wire logic       optCpu,
  input wire logic       optDelete,
  input wire logic       tosValid,
  input wire logic [1:0] tosCode,
  input wire logic       prioLow,
  input wire logic       prioHigh,
  input wire logic       memReq,
  input wire logic       resValid,
  input wire logic [1:0] resKind
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  start_busy_a: assert property (pktStart && !pktBusy |=> pktBusy)
    else $error("busy not raised after start");
  busy_hold_a: assert property (pktBusy && !resValid |=> pktBusy)
    else $error("busy dropped without result");
  res_end_a: assert property (resValid |-> pktBusy ##1 !pktBusy)
    else $error("result not at end of search");
  res_kind_a: assert property (resValid |-> resKind != 2'h3)
    else $error("illegal result kind");
  mem_idle_a: assert property (!pktBusy |-> !memReq)
    else $error("memory request while idle");
  opt_code_a: assert property (optValid && optKind != 2'h3 |=>
    {optSkip, optCpu, optDelete} == {optCode == plmc_pkg::OPT_SKIP,
    optCode == plmc_pkg::OPT_CPU, optCode == plmc_pkg::OPT_DELETE})
    else $error("option pulse disagrees with code");
  opt_cause_a: assert property (optSkip || optCpu || optDelete |-> $past(optValid))
    else $error("option pulse without request");
  tos_prio_a: assert property (tosValid |=> prioHigh == (tosCode == plmc_pkg::TOS_HIGH)
    && prioLow == (tosCode == plmc_pkg::TOS_LOW))
    else $error("priority pulse disagrees with code");
  prio_cause_a: assert property (prioLow || prioHigh |-> $past(tosValid))
    else $error("priority pulse without request");
endmodule
bind plmc_lookup plmc_lookup_chk u_chk (.sys_clk, .rst, .pktStart, .pktBusy, .optValid,
  .optKind, .optCode, .optSkip, .optCpu, .optDelete, .tosValid, .tosCode, .prioLow,
  .prioHigh, .memReq, .resValid, .resKind);

// ### plmc_lookup_tb_top.sv
`timescale 1ns/10ps
module plmc_lookup_tb_top;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic [8:0]   regAddr = 9'h000;
  logic [31:0]  regWrData = 32'h0000_0000;
  logic         regWr = 1'b0, regRd = 1'b0, pktStart = 1'b0, pktLongKey = 1'b0;
  logic [3:0]   pktProfile = 4'h0;
  logic [23:0]  pktFlowTablePtr = 24'h00_0000;
  logic [319:0] pktKey = '0;
  logic         optValid = 1'b0, tosValid = 1'b0, tosIsV6 = 1'b0;
  logic [1:0]   optKind = 2'h0;
  logic [7:0]   optValue = 8'h00, tosValue = 8'h00;
  logic [31:0]  regRdData, memData, seen, w;
  logic [1:0]   optCode, tosCode, resKind, code;
  logic         pktBusy, optSkip, optCpu, optDelete, prioLow, prioHigh;
  logic         memReq, memAck, resValid, optV1, tosV1, rdV1;
  logic [23:0]  memAddr;
  logic [3:0]   resDest, resProfile, e, q;
  logic [1:0]   act [16];
  logic [55:0]  hk;
  logic [31:0]  expQ [$];
  int           failures = 0, numChecks = 0;
  plmc_lookup dut (.sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .pktStart, .pktProfile, .pktLongKey, .pktFlowTablePtr, .pktKey, .pktBusy, .optValid,
    .optKind, .optValue, .optCode, .optSkip, .optCpu, .optDelete, .tosValid, .tosIsV6,
    .tosValue, .tosCode, .prioLow, .prioHigh, .memReq, .memAddr, .memAck, .memData,
    .resValid, .resKind, .resDest, .resProfile);
  plmc_sdram_model mdl (.sys_clk, .rst, .memReq, .memAddr, .memAck, .memData);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) {optV1, tosV1, rdV1} <= {optValid, tosValid, regRd};
  task automatic final_report();
    if (failures == 0 && numChecks > 0 && expQ.size() == 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    numChecks++;
    if (s !== x)
    begin
      failures++;
      $display("Error result expected %h seen %h", x, s);
    end
  endtask
  // CRC of n zero bits, all three registers from their seeds
  function automatic logic [55:0] zcrc(input int n);
    logic [31:0] c32;
    logic [15:0] c16;
    logic [7:0]  c8;
    c32 = plmc_pkg::CRC32_INIT;
    c16 = plmc_pkg::CRC16_INIT;
    c8 = plmc_pkg::CRC8_INIT;
    repeat (n)
    begin
      c32 = c32[31] ? (c32 << 1) ^ plmc_pkg::CRC32_POLY : c32 << 1;
      c16 = c16[15] ? (c16 << 1) ^ plmc_pkg::CRC16_POLY : c16 << 1;
      c8 = c8[7] ? (c8 << 1) ^ plmc_pkg::CRC8_POLY : c8 << 1;
    end
    return {c8, c16, c32};
  endfunction
  always @(posedge sys_clk)
    if (resValid || optV1 || tosV1 || rdV1)
    begin
      seen = resValid ? {22'h0, resDest, resKind, resProfile} : optV1 ? {27'h0, optCode,
        optSkip, optCpu, optDelete} : tosV1 ? {28'h0, tosCode, prioLow, prioHigh} : regRdData;
      chk(seen, expQ.size() ? expQ.pop_front() : ~seen);
    end
  task automatic bus(input logic [8:0] a, input logic [31:0] d, input logic rd);
    @(posedge sys_clk);
    {regAddr, regWrData, regWr, regRd} <= {a, d, !rd, rd};
    if (rd) expQ.push_back(d);
    @(posedge sys_clk);
    {regWr, regRd} <= 2'b00;
  endtask
  task automatic ev(input logic t, input logic [1:0] k, input logic [7:0] v, input logic [31:0] x);
    @(posedge sys_clk);
    {optValid, tosValid, optKind, tosIsV6, optValue, tosValue} <= {!t, t, k, k[0], v, v};
    expQ.push_back(x);
    @(posedge sys_clk);
    {optValid, tosValid} <= 2'b00;
  endtask
  task automatic srch(input logic [3:0] p, input logic lk, input logic [31:0] x);
    @(posedge sys_clk);
    {pktStart, pktProfile, pktLongKey} <= {1'b1, p, lk};
    {pktKey, pktFlowTablePtr} <= {{10{$urandom}}, 24'($urandom)};
    expQ.push_back(x);
    @(posedge sys_clk);
    pktStart <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; pktBusy !== 1'b0; i++)
    begin
      if (i == 2000)
      begin
        failures++;
        final_report();
      end
      @(posedge sys_clk);
    end
  endtask
  initial
  begin
    void'($urandom(32'h0000_A8D3));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    bus(plmc_pkg::REG_TREE_ROOT, 32'h0000_0000, 1'b0);
    bus(9'h1FF, 32'h1234_5678, 1'b0);
    bus(9'h1FF, 32'h0000_0000, 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      e = 4'($urandom);
      w = ($urandom & 32'hFFFF_FF00) | 32'h0000_00E4;
      bus({1'b0, e, plmc_pkg::W_OPT_V4 + 4'(k)}, w, 1'b0);
      bus({1'b0, e, plmc_pkg::W_OPT_V4 + 4'(k)}, w, 1'b1);
      for (int j = 0; j < 16; j++)
      begin
        code = w[2*j+:2];
        if (k < 3) ev(1'b0, 2'(k), {e, 4'(j)}, {27'h0, code, code == 2'h1, code == 2'h2, code == 2'h3});
        else ev(1'b1, 2'(k - 3), {e, 4'(j)}, {28'h0, code, code == 2'h2, code == 2'h3});
      end
    end
    // Option kind none gives no decision
    ev(1'b0, 2'h3, 8'h00, 32'h0000_0000);
    for (int p = 0; p < 16; p++)
    begin
      act[p] = (p == 3) ? 2'h2 : (p == 9) ? 2'h1 : 2'($urandom_range(2)) | {2{p[0] & p[2]}};
      mdl.mem[24'h00_1800 + 24'(p) * 24'h00_0080] = {24'h00_0000, 4'h9, 2'h0, act[p]};
    end
    for (int p = 0; p < 16; p++)
    begin
      q = (act[p] == 2'h2) ? 4'h9 : 4'(p);
      srch(4'(p), 1'($urandom), {26'h0, act[q] == 2'h1 ? plmc_pkg::RES_CPU : plmc_pkg::RES_DELETE, q});
    end
    // One node tree, zero mask for profile 2
    for (int d = 0; d < 4; d++)
      bus({1'b0, 4'h2, 4'(d)}, 32'h0000_0000, 1'b0);
    bus(plmc_pkg::REG_TREE_ROOT, 32'h0000_4000, 1'b0);
    bus(plmc_pkg::REG_TREE_ROOT, 32'h0000_4000, 1'b1);
    hk = zcrc(128);
    mdl.mem[24'h00_4000] = hk[31:0];
    mdl.mem[24'h00_4004] = {4'h0, 4'h2, hk[55:32]};
    mdl.mem[24'h00_4010] = 32'h0000_5000;
    // First structure fails its unset flow bit, chains on
    mdl.mem[24'h00_5028] = 32'h0000_6000;
    mdl.mem[24'h00_502C] = 32'h8000_2A05;
    mdl.mem[24'h00_602C] = 32'h0000_0007;
    srch(4'h2, 1'b0, {22'h0, 4'h7, plmc_pkg::RES_ROUTE, 4'h2});
    repeat (5) @(posedge sys_clk);
    final_report();
  end
endmodule

// ### plmc_pkg.sv
package plmc_pkg;

  // Identification key geometry
  localparam int              KEY_DWORDS      = 10;
  localparam logic [3:0]      LONG_KEY_LEN    = 4'hA;
  localparam logic [3:0]      SHORT_KEY_LEN   = 4'h4;
  localparam int              CRC_W           = 56;
  localparam int              PROF_W          = 4;
  localparam int              SKEY_W          = 60;

  // SDRAM addressing
  localparam int              ADDR_W          = 24;
  localparam logic [23:0]     DFLT_BASE       = 24'h00_1800;
  localparam logic [23:0]     DFLT_STRIDE     = 24'h00_0080;
  localparam logic [23:0]     NULL_PTR        = 24'h00_0000;
  localparam logic [23:0]     WORD_BYTES      = 24'h00_0004;

  // Binary tree node word indices
  localparam logic [3:0]      NODE_KEY_LO     = 4'h0;
  localparam logic [3:0]      NODE_KEY_HI     = 4'h1;
  localparam logic [3:0]      NODE_LEFT       = 4'h2;
  localparam logic [3:0]      NODE_RIGHT      = 4'h3;
  localparam logic [3:0]      NODE_CONF       = 4'h4;
  localparam int              NODE_PROF_LSB   = 24;

  // Confirmation structure word indices and fields
  localparam logic [3:0]      CONF_NEXT_WORD  = 4'hA;
  localparam logic [3:0]      CONF_CTRL_WORD  = 4'hB;
  localparam int              CONF_FT_EN_BIT  = 31;
  localparam int              CONF_IDX_LSB    = 8;
  localparam int              CONF_DEST_LSB   = 0;
  localparam int              FT_WORD_LSB     = 5;

  // Default post-search structure fields
  localparam int              DFLT_ACT_LSB    = 0;
  localparam int              DFLT_PROF_LSB   = 4;
  localparam logic [1:0]      DFLT_DELETE     = 2'h0;
  localparam logic [1:0]      DFLT_CPU        = 2'h1;
  localparam logic [1:0]      DFLT_RESEARCH   = 2'h2;

  // Option treatment codes
  localparam logic [1:0]      OPT_NONE        = 2'h0;
  localparam logic [1:0]      OPT_SKIP        = 2'h1;
  localparam logic [1:0]      OPT_CPU         = 2'h2;
  localparam logic [1:0]      OPT_DELETE      = 2'h3;

  // Service treatment codes
  localparam logic [1:0]      TOS_KEEP        = 2'h0;
  localparam logic [1:0]      TOS_RSVD        = 2'h1;
  localparam logic [1:0]      TOS_LOW         = 2'h2;
  localparam logic [1:0]      TOS_HIGH        = 2'h3;

  // Option kinds
  localparam logic [1:0]      KIND_V4         = 2'h0;
  localparam logic [1:0]      KIND_HOP        = 2'h1;
  localparam logic [1:0]      KIND_DEST       = 2'h2;

  // Profile memory word layout inside each entry
  localparam logic [3:0]      W_OPT_V4        = 4'hA;
  localparam logic [3:0]      W_OPT_HOP       = 4'hB;
  localparam logic [3:0]      W_OPT_DEST      = 4'hC;
  localparam logic [3:0]      W_TOS_V4        = 4'hD;
  localparam logic [3:0]      W_TOS_V6        = 4'hE;

  // Register port map
  localparam int              RADDR_W         = 9;
  localparam int              REG_SEL_BIT     = 8;
  localparam logic [8:0]      REG_TREE_ROOT   = 9'h100;
  localparam logic [8:0]      REG_STATUS      = 9'h101;

  // Result kinds
  localparam logic [1:0]      RES_ROUTE       = 2'h0;
  localparam logic [1:0]      RES_DELETE      = 2'h1;
  localparam logic [1:0]      RES_CPU         = 2'h2;

  // Hash polynomials and seeds
  localparam logic [31:0]     CRC32_POLY      = 32'h04C1_1DB7;
  localparam logic [15:0]     CRC16_POLY      = 16'h1021;
  localparam logic [7:0]      CRC8_POLY       = 8'h07;
  localparam logic [31:0]     CRC32_INIT      = 32'hFFFF_FFFF;
  localparam logic [15:0]     CRC16_INIT      = 16'hFFFF;
  localparam logic [7:0]      CRC8_INIT       = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HASH = 3'h1,
    ST_NODE = 3'h3,
    ST_CONF = 3'h2,
    ST_FLOW = 3'h6,
    ST_DFLT = 3'h7,
    ST_DONE = 3'h5
  } plmc_state_e;

endpackage

// ### plmc_sdram_model.sv
`timescale 1ns/10ps
module plmc_sdram_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic [23:0] memAddr,
  output logic             memAck,
  output logic      [31:0] memData
);
  logic [31:0] mem [logic [23:0]];
  logic [31:0] word = 32'h0000_0000;
  logic [1:0]  waitCnt;
  // Released bus shows inverse of last word
  assign memData = memAck ? word : ~word;
  always @(posedge sys_clk)
  begin
    memAck <= 1'b0;
    if (rst)
      waitCnt <= 2'h0;
    else if (memReq && !memAck)
    begin
      if (waitCnt == 2'h0)
      begin
        memAck <= 1'b1;
        word <= mem.exists(memAddr) ? mem[memAddr] : 32'h0000_0000;
        waitCnt <= 2'($urandom_range(2));
      end
      else
        waitCnt <= waitCnt - 2'h1;
    end
  end
endmodule
